/* File: hw/cal_consts.svh */
// Constants for the control and address load unit: field positions, masks, resets.
// Assumes inclusion from the design and checker files by bare name.
`ifndef CAL_CONSTS_SVH
`define CAL_CONSTS_SVH

// Flag and control word field positions
`define CAL_FCW_SEG_BIT   15
`define CAL_FCW_SYS_BIT   14
`define CAL_FCW_VIE_BIT   12
`define CAL_FCW_NONVECTORED_INTERRUPT_ENABLE_BIT  11
`define CAL_FCW_C_BIT     7
`define CAL_FCW_Z_BIT     6
`define CAL_FCW_S_BIT     5
`define CAL_FCW_PV_BIT    4
`define CAL_FCW_DA_BIT    3
`define CAL_FCW_H_BIT     2

// Writable and readable bits of the flag byte, control word and pointer offset registers
`define CAL_FLAG_BYTE_MASK 8'hfc
`define CAL_FCW_MASK       16'hf8fc
`define CAL_STATUS_AREA_POINTER_OFF_MASK  16'hff00

// Segment word of a segmented address: bit 15 and bits 7:0 are reserved
`define CAL_SEG_WORD_MASK  16'h7f00

// Reset values; the unit wakes in system mode so the first moves are allowed
`define CAL_FCW_RESET      16'h4000
`define CAL_STATUS_AREA_POINTER_OFF_RESET 16'h0000
`define CAL_STATUS_AREA_POINTER_SEG_RESET 16'h0000

`endif

/* File: hw/cal_pkg.sv */
// Types for the control and address load unit.
// Assumes cal_consts.svh sits on the include path.
package cal_pkg;

    typedef enum logic [3:0] {
        CAL_OP_EFFECTIVE_ADDRESS_LOAD,
        CAL_OP_PC_RELATIVE_ADDRESS_LOAD,
        CAL_OP_FLAG_BYTE_WRITE,
        CAL_OP_FLAG_BYTE_READ,
        CAL_OP_FCW_WRITE,
        CAL_OP_FCW_READ,
        CAL_OP_STATUS_AREA_POINTER_OFF_WRITE,
        CAL_OP_STATUS_AREA_POINTER_OFF_READ,
        CAL_OP_STATUS_AREA_POINTER_SEG_WRITE,
        CAL_OP_STATUS_AREA_POINTER_SEG_READ
    } cal_op_t;

    typedef enum logic [2:0] {
        CAL_AM_DIRECT_ADDRESS,
        CAL_AM_INDEXED,
        CAL_AM_BASED,
        CAL_AM_REGISTER_PLUS_INDEX,
        CAL_AM_PC_RELATIVE
    } cal_amode_t;

    typedef struct packed {
        logic        valid;
        cal_op_t     op;
        cal_amode_t  amode;
        logic [31:0] addr;
        logic [15:0] index;
        logic [31:0] base;
        logic [15:0] src;
        logic [31:0] next_pc;
    } cal_req_t;

    typedef struct packed {
        logic        done;
        logic        trap;
        logic        write_pair;
        logic        write_byte;
        logic [31:0] result;
    } cal_rsp_t;

    typedef struct packed {
        logic address_mode_select_bit;
        logic system_mode;
        logic vectored_interrupt_enable;
        logic nonvectored_interrupt_enable;
        logic carry;
        logic zero;
        logic sign;
        logic parity_overflow;
        logic decimal_adjust;
        logic half_carry;
    } cal_mode_t;

    typedef struct packed {
        logic [15:0] flag_control_word;
        logic [15:0] status_area_pointer_off;
        logic [15:0] status_area_pointer_seg;
        cal_rsp_t    rsp;
    } cal_state_t;

endpackage

/* File: hw/cal_addr_unit.sv */
// Address arithmetic for the two address loads.
// Assumes operands come from the register file on the same clock; pure combinational.
`timescale 1ns/1ps
`default_nettype none
`include "cal_consts.svh"

module cal_addr_unit
    import cal_pkg::*;
(
    // Mode
    input  wire cal_amode_t  amode,
    input  wire logic        seg_mode,
    // Operands
    input  wire logic [31:0] addr,
    input  wire logic [15:0] index,
    input  wire logic [31:0] base,
    input  wire logic [31:0] next_pc,
    // Result
    output var  logic [31:0] ea
);

    logic [15:0] off;
    logic [15:0] seg_word;

    // Offsets wrap at 16 bits and never carry into the segment
    always_comb begin
        off      = addr[15:0];
        seg_word = addr[31:16];
        case (amode)
            CAL_AM_DIRECT_ADDRESS: begin
                off      = addr[15:0];
                seg_word = addr[31:16];
            end
            CAL_AM_INDEXED: begin
                off      = addr[15:0] + index;
                seg_word = addr[31:16];
            end
            CAL_AM_BASED: begin
                off      = base[15:0] + addr[15:0];
                seg_word = base[31:16];
            end
            CAL_AM_REGISTER_PLUS_INDEX: begin
                off      = base[15:0] + index;
                seg_word = base[31:16];
            end
            CAL_AM_PC_RELATIVE: begin
                off      = next_pc[15:0] + addr[15:0];
                seg_word = next_pc[31:16] & `CAL_SEG_WORD_MASK;
            end
            default: begin
                off      = addr[15:0];
                seg_word = addr[31:16];
            end
        endcase
        ea = seg_mode ? {seg_word, off} : {16'h0000, off};
    end

endmodule
`default_nettype wire

/* File: hw/cal_core.sv */
// Control and address load unit: executes address loads and control register moves.
// Assumes the core presents one decoded request per cycle with register values already read.
`timescale 1ns/1ps
`default_nettype none
`include "cal_consts.svh"

module cal_core
    import cal_pkg::*;
#(
    parameter int DATA_W = 16
)
(
    // Clock and reset
    input  wire logic      ref_clk,
    input  wire logic      srst,
    // Decoded request from the instruction stream
    input  wire cal_req_t  req,
    // Result towards the register file
    output var  cal_rsp_t  rsp,
    // Control register contents
    output var  logic [15:0] flag_control_word,
    output var  logic [15:0] status_area_pointer_off,
    output var  logic [15:0] status_area_pointer_seg,
    output var  cal_mode_t   mode
);

    initial begin
        if (DATA_W != 16) begin
            $error("cal_core supports only a 16-bit word");
        end
    end

    cal_state_t  st;
    cal_state_t  next_st;
    logic [31:0] ea;
    logic        privileged;
    logic        system_mode;
    logic        seg_mode;
    logic [15:0] src_w;

    assign system_mode = st.flag_control_word[`CAL_FCW_SYS_BIT];
    assign seg_mode    = st.flag_control_word[`CAL_FCW_SEG_BIT];
    assign src_w       = req.src;

    cal_addr_unit u_addr (
        .amode   (req.op == CAL_OP_PC_RELATIVE_ADDRESS_LOAD ? CAL_AM_PC_RELATIVE : req.amode),
        .seg_mode(seg_mode),
        .addr    (req.addr),
        .index   (req.index),
        .base    (req.base),
        .next_pc (req.next_pc),
        .ea      (ea)
    );

    // Address loads and the flag byte move run in either mode
    always_comb begin
        case (req.op)
            CAL_OP_EFFECTIVE_ADDRESS_LOAD:   privileged = 1'b0;
            CAL_OP_PC_RELATIVE_ADDRESS_LOAD: privileged = 1'b0;
            CAL_OP_FLAG_BYTE_WRITE:          privileged = 1'b0;
            CAL_OP_FLAG_BYTE_READ:           privileged = 1'b0;
            default:                         privileged = 1'b1;
        endcase
    end

    always_comb begin
        next_st                = st;
        next_st.rsp.done       = 1'b0;
        next_st.rsp.trap       = 1'b0;
        if (req.valid) begin
            next_st.rsp.done       = 1'b1;
            next_st.rsp.write_pair = 1'b0;
            next_st.rsp.write_byte = 1'b0;
            next_st.rsp.result     = 32'h0000_0000;
            if (privileged && !system_mode) begin
                // No register changes; the core takes the privileged trap
                next_st.rsp.done = 1'b0;
                next_st.rsp.trap = 1'b1;
            end else begin
                case (req.op)
                    CAL_OP_EFFECTIVE_ADDRESS_LOAD: begin
                        // Reserved bits pass through from the operand word
                        next_st.rsp.result     = ea;
                        next_st.rsp.write_pair = seg_mode;
                    end
                    CAL_OP_PC_RELATIVE_ADDRESS_LOAD: begin
                        next_st.rsp.result     = ea;
                        next_st.rsp.write_pair = seg_mode;
                    end
                    CAL_OP_FLAG_BYTE_WRITE: begin
                        next_st.flag_control_word[7:0] = (st.flag_control_word[7:0] & ~`CAL_FLAG_BYTE_MASK)
                                         | (src_w[7:0] & `CAL_FLAG_BYTE_MASK);
                    end
                    CAL_OP_FLAG_BYTE_READ: begin
                        next_st.rsp.write_byte   = 1'b1;
                        next_st.rsp.result[7:0]  = st.flag_control_word[7:0] & `CAL_FLAG_BYTE_MASK;
                    end
                    CAL_OP_FCW_WRITE: begin
                        next_st.flag_control_word = (st.flag_control_word & ~`CAL_FCW_MASK)
                                    | (src_w & `CAL_FCW_MASK);
                    end
                    CAL_OP_FCW_READ: begin
                        next_st.rsp.result[15:0] = st.flag_control_word & `CAL_FCW_MASK;
                    end
                    CAL_OP_STATUS_AREA_POINTER_OFF_WRITE: begin
                        next_st.status_area_pointer_off = (st.status_area_pointer_off & ~`CAL_STATUS_AREA_POINTER_OFF_MASK)
                                         | (src_w & `CAL_STATUS_AREA_POINTER_OFF_MASK);
                    end
                    CAL_OP_STATUS_AREA_POINTER_OFF_READ: begin
                        next_st.rsp.result[15:0] = st.status_area_pointer_off & `CAL_STATUS_AREA_POINTER_OFF_MASK;
                    end
                    CAL_OP_STATUS_AREA_POINTER_SEG_WRITE: begin
                        // Halves update separately; interrupt safety is software's job
                        next_st.status_area_pointer_seg = src_w;
                    end
                    CAL_OP_STATUS_AREA_POINTER_SEG_READ: begin
                        next_st.rsp.result[15:0] = st.status_area_pointer_seg;
                    end
                    default: begin
                        next_st.rsp.done = 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st.flag_control_word      <= `CAL_FCW_RESET;
            st.status_area_pointer_off <= `CAL_STATUS_AREA_POINTER_OFF_RESET;
            st.status_area_pointer_seg <= `CAL_STATUS_AREA_POINTER_SEG_RESET;
            st.rsp      <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rsp      = st.rsp;
    assign flag_control_word      = st.flag_control_word;
    assign status_area_pointer_off = st.status_area_pointer_off;
    assign status_area_pointer_seg = st.status_area_pointer_seg;

    // Decoded view of the control word
    assign mode.address_mode_select_bit      = st.flag_control_word[`CAL_FCW_SEG_BIT];
    assign mode.system_mode                  = st.flag_control_word[`CAL_FCW_SYS_BIT];
    assign mode.vectored_interrupt_enable    = st.flag_control_word[`CAL_FCW_VIE_BIT];
    assign mode.nonvectored_interrupt_enable = st.flag_control_word[`CAL_FCW_NONVECTORED_INTERRUPT_ENABLE_BIT];
    assign mode.carry                        = st.flag_control_word[`CAL_FCW_C_BIT];
    assign mode.zero                         = st.flag_control_word[`CAL_FCW_Z_BIT];
    assign mode.sign                         = st.flag_control_word[`CAL_FCW_S_BIT];
    assign mode.parity_overflow              = st.flag_control_word[`CAL_FCW_PV_BIT];
    assign mode.decimal_adjust               = st.flag_control_word[`CAL_FCW_DA_BIT];
    assign mode.half_carry                   = st.flag_control_word[`CAL_FCW_H_BIT];

endmodule
`default_nettype wire

/* File: tb/cal_core_properties.sv */
// Checker for the control and address load unit, seeing only the top-level ports.
// Assumes cal_pkg is compiled first; bound into cal_core at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
`include "cal_consts.svh"

module cal_core_properties
    import cal_pkg::*;
#(
    parameter int DATA_W = 16
)
(
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        srst,
    // Request and response
    input wire cal_req_t    req,
    input wire cal_rsp_t    rsp,
    // Control registers
    input wire logic [15:0] flag_control_word,
    input wire logic [15:0] status_area_pointer_off,
    input wire logic [15:0] status_area_pointer_seg,
    input wire cal_mode_t   mode
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence s_take(cal_op_t o);
        req.valid && req.op == o;
    endsequence
    sequence s_sys_take(cal_op_t o);
        s_take(o) ##0 flag_control_word[14];
    endsequence

    property p_fcw_wr;
        s_sys_take(CAL_OP_FCW_WRITE) |=> rsp.done &&
            flag_control_word == (($past(flag_control_word) & ~`CAL_FCW_MASK) | ($past(req.src) & `CAL_FCW_MASK));
    endproperty
    a_fcw_wr: assert property (p_fcw_wr) else $error("control word write wrong");
    property p_fcw_rd;
        s_sys_take(CAL_OP_FCW_READ) |=> rsp.result[15:0] == ($past(flag_control_word) & `CAL_FCW_MASK);
    endproperty
    a_fcw_rd: assert property (p_fcw_rd) else $error("control word read wrong");
    property p_flag_wr;
        s_take(CAL_OP_FLAG_BYTE_WRITE) |=>
            flag_control_word == {$past(flag_control_word[15:8]), $past(req.src[7:2]), $past(flag_control_word[1:0])};
    endproperty
    a_flag_wr: assert property (p_flag_wr) else $error("flag byte write wrong");
    property p_flag_rd;
        s_take(CAL_OP_FLAG_BYTE_READ) |=>
            rsp.write_byte && rsp.result[7:0] == {$past(flag_control_word[7:2]), 2'b00};
    endproperty
    a_flag_rd: assert property (p_flag_rd) else $error("flag byte read wrong");
    property p_flag_any;
        s_take(CAL_OP_FLAG_BYTE_WRITE) or s_take(CAL_OP_FLAG_BYTE_READ) |=> rsp.done && !rsp.trap;
    endproperty
    a_flag_any: assert property (p_flag_any) else $error("flag byte move refused");
    property p_off_wr;
        s_sys_take(CAL_OP_STATUS_AREA_POINTER_OFF_WRITE) |=>
            status_area_pointer_off == {$past(req.src[15:8]), $past(status_area_pointer_off[7:0])};
    endproperty
    a_off_wr: assert property (p_off_wr) else $error("pointer offset write wrong");
    property p_off_rd;
        s_sys_take(CAL_OP_STATUS_AREA_POINTER_OFF_READ) |=>
            rsp.result[15:0] == {$past(status_area_pointer_off[15:8]), 8'h00} && $stable(status_area_pointer_off);
    endproperty
    a_off_rd: assert property (p_off_rd) else $error("pointer offset read wrong");
    property p_trap;
        req.valid && req.op >= CAL_OP_FCW_WRITE && !flag_control_word[14] |=> rsp.trap && !rsp.done &&
            $stable(flag_control_word) && $stable(status_area_pointer_off) && $stable(status_area_pointer_seg);
    endproperty
    a_trap: assert property (p_trap) else $error("privileged move not trapped");
    property p_pcrel;
        s_take(CAL_OP_PC_RELATIVE_ADDRESS_LOAD) |=> rsp.write_pair == $past(flag_control_word[15]) &&
            rsp.result[15:0] == $past(req.next_pc[15:0]) + $past(req.addr[15:0]) &&
            rsp.result[31:16] == ($past(req.next_pc[31:16]) & {16{$past(flag_control_word[15])}} & 16'h7f00);
    endproperty
    a_pcrel: assert property (p_pcrel) else $error("relative address wrong");
    property p_mode;
        mode == {flag_control_word[15:14], flag_control_word[12:11], flag_control_word[7:2]};
    endproperty
    a_mode: assert property (p_mode) else $error("mode bits differ from control word");
endmodule

bind cal_core cal_core_properties #(.DATA_W(DATA_W)) i_cal_core_properties (.ref_clk(ref_clk),
    .srst(srst), .req(req), .rsp(rsp), .flag_control_word(flag_control_word), .status_area_pointer_off(status_area_pointer_off), .status_area_pointer_seg(status_area_pointer_seg),
    .mode(mode));
`default_nettype wire

/* File: tb/test_control_and_address_loads.sv */
// Testbench for cal_core: issues decoded requests and checks results and registers.
// Assumes cal_pkg and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none

module test_control_and_address_loads
    import cal_pkg::*;
;
    logic        ref_clk     = 1'b0;
    logic        srst        = 1'b1;
    cal_req_t    req         = '0;
    cal_rsp_t    rsp;
    cal_rsp_t    r;
    logic [15:0] flag_control_word;
    logic [15:0] status_area_pointer_off;
    logic [15:0] status_area_pointer_seg;
    cal_mode_t   mode;
    int          fails       = 0;
    int          checks_done = 0;

    always #5 ref_clk = ~ref_clk;

    cal_core i_cal_core (.ref_clk(ref_clk), .srst(srst), .req(req), .rsp(rsp), .flag_control_word(flag_control_word),
        .status_area_pointer_off(status_area_pointer_off), .status_area_pointer_seg(status_area_pointer_seg), .mode(mode));

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask

    // One request, then wait a bounded time for done or trap
    task automatic run(input cal_op_t o, input logic [15:0] s, input logic [31:0] a = 0,
                       input logic [31:0] b = 0, input logic [15:0] x = 0,
                       input logic [31:0] pc = 0, input cal_amode_t am = CAL_AM_DIRECT_ADDRESS);
        int n;
        n = 0;
        @(posedge ref_clk);
        req <= '{1'b1, o, am, a, x, b, s, pc};
        @(posedge ref_clk);
        req.valid <= 1'b0;
        #1;
        while (rsp.done !== 1'b1 && rsp.trap !== 1'b1 && n < 4) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n == 4) begin
            fails++;
            conclude();
        end
        r = rsp;
    endtask

    initial begin
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        #1;
        chk({flag_control_word, status_area_pointer_off, status_area_pointer_seg}, {16'h4000, 32'h0});
        run(CAL_OP_FCW_WRITE, 16'hffff);
        chk(flag_control_word, 16'hf8fc);
        chk(mode, 10'h3ff);
        run(CAL_OP_FCW_READ, 16'h0000);
        chk(r.result[15:0], 16'hf8fc);
        run(CAL_OP_FLAG_BYTE_WRITE, 16'h00a7);
        chk(flag_control_word, 16'hf8a4);
        run(CAL_OP_FLAG_BYTE_READ, 16'h0000);
        chk({r.write_byte, r.result[7:0]}, 9'h1a4);
        run(CAL_OP_STATUS_AREA_POINTER_OFF_WRITE, 16'h12ab);
        chk(status_area_pointer_off, 16'h1200);
        run(CAL_OP_STATUS_AREA_POINTER_OFF_READ, 16'h0000);
        chk(r.result[15:0], 16'h1200);
        run(CAL_OP_STATUS_AREA_POINTER_SEG_WRITE, 16'h7f00);
        chk(status_area_pointer_seg, 16'h7f00);
        run(CAL_OP_STATUS_AREA_POINTER_SEG_READ, 16'h0000);
        chk({r.done, r.result[15:0]}, 17'h1_7f00);
        $display("Test control moves done");
        // Segmented: reserved bits may be anything for based and indexed loads; the relative load expects them zero
        run(CAL_OP_PC_RELATIVE_ADDRESS_LOAD, 0, 32'h0000_fffe, 0, 0, 32'h7f12_1000);
        chk({r.write_pair, r.result}, 33'h1_7f00_0ffe);
        run(CAL_OP_EFFECTIVE_ADDRESS_LOAD, 0, 32'h8, 32'h0100_0020, 0, 0, CAL_AM_BASED);
        chk({r.write_pair, r.result[30:24], r.result[15:0]}, 24'h81_0028);
        run(CAL_OP_EFFECTIVE_ADDRESS_LOAD, 0, 32'h0300_0008, 0, 16'h0020, 0, CAL_AM_INDEXED);
        chk({r.write_pair, r.result[30:24], r.result[15:0]}, 24'h83_0028);
        run(CAL_OP_FCW_WRITE, 16'h4000);
        chk(flag_control_word, 16'h4000);
        run(CAL_OP_EFFECTIVE_ADDRESS_LOAD, 0, 32'h0000_1234);
        chk({r.write_pair, r.result}, 33'h0_0000_1234);
        run(CAL_OP_EFFECTIVE_ADDRESS_LOAD, 0, 0, 32'h20, 16'h8, 0, CAL_AM_REGISTER_PLUS_INDEX);
        chk({r.write_pair, r.result}, 33'h0_0000_0028);
        run(CAL_OP_PC_RELATIVE_ADDRESS_LOAD, 0, 32'h0000_8000, 0, 0, 32'h0000_0002);
        chk({r.write_pair, r.result}, 33'h0_0000_8002);
        $display("Test address loads done");
        run(CAL_OP_FCW_WRITE, 16'h0000);
        run(CAL_OP_FLAG_BYTE_WRITE, 16'h005f);
        chk({r.trap, r.done, flag_control_word}, {2'b01, 16'h005c});
        for (int k = 4; k < 10; k++) begin
            run(cal_op_t'(k), 16'hffff);
            chk({r.trap, r.done, flag_control_word, status_area_pointer_off, status_area_pointer_seg}, {2'b10, 48'h005c_1200_7f00});
        end
        $display("Test normal mode done");
        @(posedge ref_clk);
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        #1;
        chk({flag_control_word, status_area_pointer_off, status_area_pointer_seg}, {16'h4000, 32'h0});
        $display("Test second reset done");
        conclude();
    end
endmodule
`default_nettype wire
